/* File: ftr_pkg.sv */
// package: offsets, field layouts, reset values and carriers of the tape/rate registers
package ftr_pkg;
  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_SHADOW = 10'h01F; // rate shadow, readable
  localparam logic [9:0] IDX_MODE = 10'h3E0; // mode, drive rate type, boot drive
  localparam logic [9:0] IDX_DTYPE = 10'h3E1; // drive type config byte
  localparam logic [9:0] IDX_STATUS = 10'h3E2; // block state, read only
  localparam logic [9:0] IDX_DOR = 10'h3F2; // digital output reg
  localparam logic [9:0] IDX_TAPE = 10'h3F3; // tape drive assign
  localparam logic [9:0] IDX_RATE = 10'h3F4; // rate select (w) / main status (r)
  localparam logic [9:0] IDX_DATA = 10'h3F5; // data register window
  localparam logic [9:0] IDX_CCR = 10'h3F7; // config control reg (write)
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RATE_SWRST_BIT = 7;
  localparam int RATE_PWRDN_BIT = 6;
  localparam int RATE_PRE_LSB = 2;
  localparam int DOR_RESET_BIT = 2;
  localparam int MODE_ENH_BIT = 0;
  localparam int MODE_DRT_LSB = 1;
  localparam int MODE_BOOT_LSB = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RATE_RST = 8'h02; // default precomp, 250 kbps
  localparam logic [7:0] TAPE_RST = 8'h00;
  localparam logic [7:0] DOR_RST = 8'h00; // controller held in reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DTYPE_RST = 8'h00;
  localparam logic [7:0] TRACK_RST = 8'h00; // precomp starts at track 0
  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [2:0] PRE_NONE = 3'h7;
  localparam logic [2:0] PRE_DEFAULT = 3'h0;
  localparam logic [2:0] PRE_DEF_SLOW = 3'h3; // 125 ns in 41.67 ns steps
  localparam logic [2:0] PRE_DEF_FAST = 3'h1; // one step at 1M and 2M
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int SWRST_NS = 100; // least reset pulse
  localparam int SWRST_CYC = (SWRST_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RATE_250K, RATE_300K, RATE_500K, RATE_1M, RATE_2M
  } ftr_rate_type;
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address; // byte address
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ftr_av_req_type;
  typedef struct packed {
    logic [2:0] shift_steps; // number of precomp steps
    logic half_step; // step is 20.8 ns instead of 41.67 ns
    logic [7:0] start_track;
  } ftr_precomp_type;
endpackage

/* File: ftr_regs.sv */
// tape drive assign and rate select registers behind an Avalon-MM slave
//
// Operation
// - tape select code names drive 1-3 or none
// - drive 0 never gets tape handling
// - tape handling follows assigned drive automatically
// - normal mode reads bits 7:2 as zero
// - software reset keeps tape assignment
// - enhanced mode adds drive type, boot drive
// - drive type pair picked by selected drive
// - rate select is write only, fixed layout
// - hardware reset loads 02H; software reset keeps it
// - newest rate or config write sets rate
// - precomp code sets write shift steps
// - precomp start track defaults 0, configurable
// - power down bit enters manual low power
// - reset or data/status access leaves low power
// - rate bit 7 resets controller, self clears
// - rate writes copied into readable shadow
// - rate code and drive rate type give data rate
// - default precomp depends on data rate
// - output reset bit holds controller in reset
// - read at rate address returns main status
`timescale 1ns/100ps
`default_nettype none
module ftr_regs #(
  parameter int SWRST_CYCLES = ftr_pkg::SWRST_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ftr_pkg::ftr_av_req_type av_req_i,
  output logic av_waitrequest_o,
  output logic [31:0] av_readdata_o,
  input wire logic [7:0] main_status_i,
  input wire logic track_we_i,
  input wire logic [7:0] track_i,
  output logic ctrl_reset_o,
  output logic low_power_o,
  output logic [1:0] drive_sel_o,
  output logic tape_active_o,
  output logic [1:0] tape_drive_o,
  output ftr_pkg::ftr_rate_type data_rate_o,
  output ftr_pkg::ftr_precomp_type precomp_o
);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  logic wait_q; // waitrequest, high while idle
  logic [31:0] rdata_q; // registered read data
  logic req; // read or write presented
  logic fire; // request completes this edge
  logic [9:0] idx; // register index
  logic wr_ok; // write with lane 0 enabled
  logic rd; // read completes
  logic wr_rate;
  logic wr_ccr;
  logic wr_dor;
  logic wr_tape;
  logic wr_mode;
  logic wr_dtype;
  logic wake; // data or main status access

  assign req = av_req_i.read | av_req_i.write;
  assign fire = req & ~wait_q;
  assign idx = av_req_i.address[11:2];
  assign wr_ok = fire & av_req_i.write & av_req_i.byteenable[0];
  assign rd = fire & av_req_i.read;
  assign wr_rate = wr_ok & (idx == ftr_pkg::IDX_RATE);
  assign wr_ccr = wr_ok & (idx == ftr_pkg::IDX_CCR);
  assign wr_dor = wr_ok & (idx == ftr_pkg::IDX_DOR);
  assign wr_tape = wr_ok & (idx == ftr_pkg::IDX_TAPE);
  assign wr_mode = wr_ok & (idx == ftr_pkg::IDX_MODE);
  assign wr_dtype = wr_ok & (idx == ftr_pkg::IDX_DTYPE);
  // any access at the data port, or a status read at the rate address
  assign wake = (fire & (idx == ftr_pkg::IDX_DATA)) |
                (rd & (idx == ftr_pkg::IDX_RATE));

  // one wait cycle per request, then low for exactly one edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] rate_q; // last rate select write, bit 7 self clears
  logic [1:0] rate_code_q; // active rate code, last of rate or ccr
  logic [7:0] shadow_q; // readable copy of rate writes
  logic [7:0] dor_q; // drive select and reset bit
  logic [1:0] tape_q; // tape select pair
  logic [7:0] mode_q; // enhanced mode, drive rate type, boot drive
  logic [7:0] dtype_q; // drive type config byte
  logic [7:0] track_q; // precomp start track
  logic lp_q; // manual low power
  logic [3:0] swrst_cnt_q; // self-clearing reset pulse counter
  logic rst_out_q; // controller reset output

  // rate select: hardware reset reloads it, the end of the reset pulse clears bit 7
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_q <= ftr_pkg::RATE_RST;
    end
    else if (wr_rate)
    begin
      rate_q <= av_req_i.writedata[7:0];
    end
    else if (swrst_cnt_q == 4'h1)
    begin
      rate_q[ftr_pkg::RATE_SWRST_BIT] <= 1'b0;
    end
  end

  // active rate: whichever of the two registers was written last
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_code_q <= ftr_pkg::RATE_RST[1:0];
    end
    else if (wr_rate | wr_ccr)
    begin
      rate_code_q <= av_req_i.writedata[1:0];
    end
  end

  // shadow copy follows every rate write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shadow_q <= ftr_pkg::RATE_RST;
    end
    else if (wr_rate)
    begin
      shadow_q <= av_req_i.writedata[7:0];
    end
  end

  // digital output reg: reset bit and drive select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dor_q <= ftr_pkg::DOR_RST;
    end
    else if (wr_dor)
    begin
      dor_q <= av_req_i.writedata[7:0];
    end
  end

  // tape select survives software reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tape_q <= ftr_pkg::TAPE_RST[1:0];
    end
    else if (wr_tape)
    begin
      tape_q <= av_req_i.writedata[1:0];
    end
  end

  // mode and drive type config
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= ftr_pkg::MODE_RST;
      dtype_q <= ftr_pkg::DTYPE_RST;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_q <= av_req_i.writedata[7:0];
      end
      if (wr_dtype)
      begin
        dtype_q <= av_req_i.writedata[7:0];
      end
    end
  end

  // precomp start track, changed by the configure command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      track_q <= ftr_pkg::TRACK_RST;
    end
    else if (track_we_i)
    begin
      track_q <= track_i;
    end
  end

  // ----------------------------------------
  // software reset and low power
  // ----------------------------------------
  logic swrst_start; // rate write with bit 7 set
  logic soft_reset; // any software reset active

  assign swrst_start = wr_rate & av_req_i.writedata[ftr_pkg::RATE_SWRST_BIT];
  assign soft_reset = (swrst_cnt_q != 4'h0) | ~dor_q[ftr_pkg::DOR_RESET_BIT];

  // pulse counter; a new request restarts the full length
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      swrst_cnt_q <= 4'h0;
    end
    else if (swrst_start)
    begin
      swrst_cnt_q <= 4'(SWRST_CYCLES);
    end
    else if (swrst_cnt_q != 4'h0)
    begin
      swrst_cnt_q <= swrst_cnt_q - 4'h1;
    end
  end

  // reset out: held by the output reg bit or the pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_out_q <= 1'b1;
    end
    else
    begin
      rst_out_q <= soft_reset | swrst_start;
    end
  end

  // low power: a power down write wins over any clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lp_q <= 1'b0;
    end
    else if (wr_rate & av_req_i.writedata[ftr_pkg::RATE_PWRDN_BIT])
    begin
      lp_q <= 1'b1;
    end
    else if (soft_reset | wake)
    begin
      lp_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // tape, drive type and rate decode
  // ----------------------------------------
  logic [1:0] drv; // currently selected drive
  logic [1:0] dtype_pair; // drive type id of selected drive
  logic [1:0] drt; // drive rate type
  ftr_pkg::ftr_rate_type rate_d;
  ftr_pkg::ftr_precomp_type pre_d;
  logic [2:0] pre_code;

  assign drv = dor_q[1:0];
  assign drt = mode_q[ftr_pkg::MODE_DRT_LSB +: 2];
  assign pre_code = rate_q[ftr_pkg::RATE_PRE_LSB +: 3];

  // one pair of the config byte per drive
  always_comb
  begin
    dtype_pair = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (drv == 2'(i))
      begin
        dtype_pair = dtype_q[2*i +: 2];
      end
    end
  end

  // rate code to data rate
  always_comb
  begin
    case (rate_code_q)
      2'h3: rate_d = ftr_pkg::RATE_1M;
      2'h0: rate_d = ftr_pkg::RATE_500K;
      2'h1:
      begin
        if (drt == 2'h2)
        begin
          rate_d = ftr_pkg::RATE_2M;
        end
        else if (drt == 2'h1)
        begin
          rate_d = ftr_pkg::RATE_500K; // three-mode drive
        end
        else
        begin
          rate_d = ftr_pkg::RATE_300K;
        end
      end
      default: rate_d = ftr_pkg::RATE_250K;
    endcase
  end

  // precomp: steps of 41.67 ns, or 20.8 ns at 2M
  always_comb
  begin
    pre_d.half_step = (rate_d == ftr_pkg::RATE_2M);
    pre_d.start_track = track_q;
    case (pre_code)
      ftr_pkg::PRE_NONE: pre_d.shift_steps = 3'h0;
      ftr_pkg::PRE_DEFAULT:
      begin
        if (rate_d == ftr_pkg::RATE_1M || rate_d == ftr_pkg::RATE_2M)
        begin
          pre_d.shift_steps = ftr_pkg::PRE_DEF_FAST;
        end
        else
        begin
          pre_d.shift_steps = ftr_pkg::PRE_DEF_SLOW;
        end
      end
      default: pre_d.shift_steps = pre_code;
    endcase
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rd_byte;

  // unmapped and write-only addresses read as zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx)
      ftr_pkg::IDX_TAPE:
      begin
        rd_byte = {6'h00, tape_q};
        if (mode_q[ftr_pkg::MODE_ENH_BIT])
        begin
          rd_byte = {2'h0, dtype_pair, mode_q[ftr_pkg::MODE_BOOT_LSB +: 2], tape_q};
        end
      end
      ftr_pkg::IDX_RATE: rd_byte = main_status_i;
      ftr_pkg::IDX_SHADOW: rd_byte = shadow_q;
      ftr_pkg::IDX_DOR: rd_byte = dor_q;
      ftr_pkg::IDX_MODE: rd_byte = mode_q;
      ftr_pkg::IDX_DTYPE: rd_byte = dtype_q;
      ftr_pkg::IDX_STATUS: rd_byte = {3'h0, rate_d, lp_q, rst_out_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // read data stands at the edge where waitrequest is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (av_req_i.read & wait_q)
    begin
      rdata_q <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic tape_hit;

  // drive 0 is never a tape drive since code 00 means none
  assign tape_hit = (tape_q != 2'h0) & (drv == tape_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tape_active_o <= 1'b0;
      data_rate_o <= ftr_pkg::RATE_250K;
      precomp_o <= '0;
    end
    else
    begin
      tape_active_o <= tape_hit;
      data_rate_o <= rate_d;
      precomp_o <= pre_d;
    end
  end

  assign av_waitrequest_o = wait_q;
  assign av_readdata_o = rdata_q;
  assign ctrl_reset_o = rst_out_q;
  assign low_power_o = lp_q;
  assign drive_sel_o = dor_q[1:0];
  assign tape_drive_o = tape_q;
endmodule
`default_nettype wire

/* File: ftr_regs_assertions.sv */
// checker: bus, reset pulse, tape and low power properties of the register block
`timescale 1ns/100ps
`default_nettype none
module ftr_regs_chk #(
  parameter int SWRST_CYCLES = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ftr_pkg::ftr_av_req_type av_req_i,
  input wire logic av_waitrequest_o,
  input wire logic [31:0] av_readdata_o,
  input wire logic [7:0] main_status_i,
  input wire logic track_we_i,
  input wire logic [7:0] track_i,
  input wire logic ctrl_reset_o,
  input wire logic low_power_o,
  input wire logic [1:0] drive_sel_o,
  input wire logic tape_active_o,
  input wire logic [1:0] tape_drive_o,
  input wire ftr_pkg::ftr_rate_type data_rate_o,
  input wire ftr_pkg::ftr_precomp_type precomp_o
);
  // ----------------------------------------
  // decode of the completing transfer
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [9:0] idx = av_req_i.address[11:2]; // register index
  wire logic acc = (av_req_i.read || av_req_i.write) && !av_waitrequest_o; // any access
  wire logic rd_ok = av_req_i.read && !av_waitrequest_o; // read completes
  wire logic wr_ok = acc && av_req_i.write && av_req_i.byteenable[0]; // write lands
  wire logic [7:0] wd = av_req_i.writedata[7:0]; // written byte
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_TAPE_READ: assert property (rd_ok && idx == ftr_pkg::IDX_TAPE |->
    av_readdata_o[1:0] == tape_drive_o && av_readdata_o[31:8] == 24'h0)
    else $error("tape read data wrong");
  AST_TAPE_KEEP: assert property (!(wr_ok && idx == ftr_pkg::IDX_TAPE) |=>
    $stable(tape_drive_o)) else $error("tape select changed without write");
  AST_TAPE_ACTIVE: assert property (1'b1 |-> tape_active_o ==
    ($past(drive_sel_o) == $past(tape_drive_o) && $past(tape_drive_o) != 2'h0))
    else $error("tape handling wrong for selected drive");
  AST_SWRST: assert property (wr_ok && idx == ftr_pkg::IDX_RATE && wd[7] |=>
    ctrl_reset_o [*3]) else $error("software reset pulse too short");
  AST_DOR_RST: assert property (wr_ok && idx == ftr_pkg::IDX_DOR && !wd[2] |=>
    ##1 ctrl_reset_o) else $error("output reset bit did not hold reset");
  AST_PWRDN: assert property (wr_ok && idx == ftr_pkg::IDX_RATE && wd[6] |=>
    low_power_o) else $error("power down not entered");
  AST_WAKE: assert property ((rd_ok && idx == ftr_pkg::IDX_RATE) ||
    (acc && idx == ftr_pkg::IDX_DATA) |=> !low_power_o) else $error("low power not left");
  AST_MSR_READ: assert property (rd_ok && idx == ftr_pkg::IDX_RATE |->
    av_readdata_o[7:0] == $past(main_status_i)) else $error("status read wrong");
  AST_TRACK: assert property (track_we_i |=>
    ##1 precomp_o.start_track == $past(track_i, 2)) else $error("start track not loaded");
  // main scenarios reached
  cover property (wr_ok && idx == ftr_pkg::IDX_RATE && wd[7]);
  cover property (tape_active_o);
  cover property (low_power_o ##1 !low_power_o);
  cover property (wr_ok && idx == ftr_pkg::IDX_DOR && !wd[2]);
endmodule
bind ftr_regs ftr_regs_chk #(.SWRST_CYCLES(SWRST_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .av_req_i(av_req_i), .av_waitrequest_o(av_waitrequest_o),
  .av_readdata_o(av_readdata_o), .main_status_i(main_status_i), .track_we_i(track_we_i),
  .track_i(track_i), .ctrl_reset_o(ctrl_reset_o), .low_power_o(low_power_o),
  .drive_sel_o(drive_sel_o), .tape_active_o(tape_active_o), .tape_drive_o(tape_drive_o),
  .data_rate_o(data_rate_o), .precomp_o(precomp_o));
`default_nettype wire

/* File: ftr_drive_model.sv */
// drive-side model: status byte and precomp start track from the controller core
`timescale 1ns/100ps
`default_nettype none
module ftr_drive_model (
  input wire logic clk_i,
  input wire logic [7:0] status_i,
  input wire logic go_i,
  input wire logic [7:0] track_i,
  output logic [7:0] main_status_o,
  output logic track_we_o,
  output logic [7:0] track_o
);
  // one load pulse per request; track bus inverts its own value every cycle when not loading
  always_ff @(posedge clk_i)
  begin
    main_status_o <= status_i;
    track_we_o <= go_i;
    track_o <= go_i ? track_i : ~track_o;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// testbench: tape assign and rate select registers over the slave bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i, rst_i, trk_go, trk_we, wait_w, ctrl_rst, lp, tact;
  ftr_pkg::ftr_av_req_type req; // bus request
  logic [31:0] rdata;
  logic [7:0] status_w, st_set, trk_set, trk, q, tape, dt;
  logic [1:0] dsel, tdrv;
  ftr_pkg::ftr_rate_type rate;
  ftr_pkg::ftr_precomp_type pre;
  int errors, n_compared, cyc, n;
  ftr_drive_model u_drv (.clk_i(clk_i), .status_i(st_set), .go_i(trk_go), .track_i(trk_set),
    .main_status_o(status_w), .track_we_o(trk_we), .track_o(trk));
  ftr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .av_req_i(req), .av_waitrequest_o(wait_w),
    .av_readdata_o(rdata), .main_status_i(status_w), .track_we_i(trk_we), .track_i(trk),
    .ctrl_reset_o(ctrl_rst), .low_power_o(lp), .drive_sel_o(dsel), .tape_active_o(tact),
    .tape_drive_o(tdrv), .data_rate_o(rate), .precomp_o(pre));
  // clock, 40 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard, far above the planned run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      stop_test();
    end
  end
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  // one transfer; holds until waitrequest is seen low
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{read: !w, write: w, address: {i, 2'h0}, byteenable: 4'hF, writedata: {24'h0, d}};
    do @(posedge clk_i); while (wait_w !== 1'b0);
    q = rdata[7:0];
    req <= '0;
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
  endtask
  function automatic ftr_pkg::ftr_rate_type rate_exp(input logic [1:0] drt, input logic [1:0] c);
    if (c == 2'h3) return ftr_pkg::RATE_1M;
    if (c == 2'h0) return ftr_pkg::RATE_500K;
    if (c == 2'h2) return ftr_pkg::RATE_250K;
    if (drt == 2'h1) return ftr_pkg::RATE_500K; // three-mode drive
    return (drt == 2'h2) ? ftr_pkg::RATE_2M : ftr_pkg::RATE_300K;
  endfunction
  // steps and half-step flag for a precomp code at a rate
  function automatic logic [3:0] pre_exp(input logic [2:0] c, input ftr_pkg::ftr_rate_type r);
    if (c == 3'h7) return 4'h0;
    if (c != 3'h0) return {c, r == ftr_pkg::RATE_2M};
    return (r >= ftr_pkg::RATE_1M) ? {3'h1, r == ftr_pkg::RATE_2M} : 4'h6;
  endfunction
  task stop_test;
    $display("counts: compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    st_set = 8'h00;
    trk_set = 8'h00;
    trk_go = 1'b0;
    void'($urandom(68956));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(ctrl_rst, 1'b1)
    `CHK(rate, ftr_pkg::RATE_250K)
    `CHK(tdrv, 2'h0)
    $display("test reset done");
    bus(1'b1, ftr_pkg::IDX_DOR, 8'h04);
    settle();
    `CHK(ctrl_rst, 1'b0)
    // every tape code against every selected drive
    for (int t = 0; t < 4; t++)
    begin
      tape = {6'($urandom()), 2'(t)};
      bus(1'b1, ftr_pkg::IDX_TAPE, tape);
      bus(1'b0, ftr_pkg::IDX_TAPE, 8'h00);
      `CHK(q, 8'(t))
      `CHK(tdrv, 2'(t))
      for (int d = 0; d < 4; d++)
      begin
        bus(1'b1, ftr_pkg::IDX_DOR, 8'h04 | 8'(d));
        settle();
        `CHK(tact, 1'(t != 0 && d == t))
        `CHK(dsel, 2'(d))
      end
    end
    $display("test tape done");
    // enhanced mode, boot drive 2
    dt = 8'($urandom());
    bus(1'b1, ftr_pkg::IDX_DTYPE, dt);
    bus(1'b1, ftr_pkg::IDX_MODE, 8'h11);
    for (int d = 0; d < 4; d++)
    begin
      bus(1'b1, ftr_pkg::IDX_DOR, 8'h04 | 8'(d));
      bus(1'b0, ftr_pkg::IDX_TAPE, 8'h00);
      `CHK(q, {2'h0, dt[2*d+:2], 2'h2, 2'h3})
    end
    $display("test enhanced done");
    // rate codes, config control override, default precomp
    for (int r = 0; r < 3; r++)
    begin
      bus(1'b1, ftr_pkg::IDX_MODE, 8'(r << 1));
      for (int c = 0; c < 4; c++)
      begin
        bus(1'b1, ftr_pkg::IDX_RATE, 8'(c));
        settle();
        `CHK(rate, rate_exp(2'(r), 2'(c)))
        `CHK({pre.shift_steps, pre.half_step}, pre_exp(3'h0, rate_exp(2'(r), 2'(c))))
        bus(1'b1, ftr_pkg::IDX_CCR, 8'(3 - c));
        settle();
        `CHK(rate, rate_exp(2'(r), 2'(3 - c)))
      end
    end
    bus(1'b1, ftr_pkg::IDX_MODE, 8'h00);
    // precomp codes and the readable shadow
    for (int c = 1; c < 8; c++)
    begin
      bus(1'b1, ftr_pkg::IDX_RATE, 8'((c << 2) | 2));
      settle();
      `CHK({pre.shift_steps, pre.half_step}, pre_exp(3'(c), ftr_pkg::RATE_250K))
      bus(1'b0, ftr_pkg::IDX_SHADOW, 8'h00);
      `CHK(q, 8'((c << 2) | 2))
    end
    $display("test rate done");
    // self clearing reset keeps tape and rate
    bus(1'b1, ftr_pkg::IDX_RATE, 8'h8E);
    @(posedge clk_i);
    `CHK(ctrl_rst, 1'b1)
    for (n = 0; n < 20 && ctrl_rst !== 1'b0; n++) @(posedge clk_i);
    `CHK(ctrl_rst, 1'b0)
    // output reg reset bit held low, then released
    bus(1'b1, ftr_pkg::IDX_DOR, 8'h03);
    settle();
    `CHK(ctrl_rst, 1'b1)
    bus(1'b1, ftr_pkg::IDX_DOR, 8'h07);
    settle();
    `CHK(ctrl_rst, 1'b0)
    bus(1'b0, ftr_pkg::IDX_TAPE, 8'h00);
    `CHK(q, 8'h03)
    `CHK(rate, ftr_pkg::RATE_250K)
    // low power left by status read, data access, software reset
    st_set <= 8'($urandom());
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, ftr_pkg::IDX_RATE, 8'h42);
      settle();
      `CHK(lp, 1'b1)
      if (k == 0)
      begin
        bus(1'b0, ftr_pkg::IDX_RATE, 8'h00);
        `CHK(q, st_set)
      end
      else
        bus(1'b1, (k == 1) ? ftr_pkg::IDX_DATA : ftr_pkg::IDX_RATE, (k == 1) ? 8'h00 : 8'h82);
      settle();
      `CHK(lp, 1'b0)
    end
    settle();
    bus(1'b0, 10'h100, 8'h00);
    `CHK(q, 8'h00)
    // start track load from the drive side
    trk_set <= 8'($urandom());
    trk_go <= 1'b1;
    @(posedge clk_i);
    trk_go <= 1'b0;
    settle();
    `CHK(pre.start_track, trk_set)
    $display("test power and track done");
    // hardware reset in mid-run reloads the rate select value
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(rate, ftr_pkg::RATE_250K)
    bus(1'b0, ftr_pkg::IDX_SHADOW, 8'h00);
    `CHK(q, ftr_pkg::RATE_RST)
    $display("test hardware reset done");
    // random tape writes mixed with status reads
    repeat (40)
    begin
      tape = 8'($urandom());
      bus(1'b1, ftr_pkg::IDX_TAPE, tape);
      st_set <= 8'($urandom());
      bus(1'b0, ftr_pkg::IDX_RATE, 8'h00);
      `CHK(q, st_set)
      bus(1'b0, ftr_pkg::IDX_TAPE, 8'h00);
      `CHK(q, {6'h0, tape[1:0]})
    end
    $display("test random done");
    stop_test();
  end
endmodule
`default_nettype wire
